// ### rtl/spi_cmd_pkg.sv
package spi_cmd_pkg;
  // Serial framing.
  localparam int BYTE_BITS = 8;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [3:0] ADDR_BCAST = 4'hF;
  localparam logic [3:0] ADDR_BOTTOM = 4'h0;
  localparam logic [7:0] SUM_OK = 8'hFF;
  localparam logic [7:0] TX_IDLE = 8'hFF;
  // Command codes.
  localparam logic [2:0] CODE_SLEEP_CLR = 3'h0;
  localparam logic [2:0] CODE_WAKE_SET = 3'h1;
  localparam logic [2:0] CODE_CHG_VREAD = 3'h2;
  localparam logic [2:0] CODE_DSG_IREAD = 3'h3;
  localparam logic [2:0] CODE_ADDR_UPD = 3'h4;
  // Write selector in data bits 23:21.
  localparam logic [2:0] SEL_BALANCE = 3'h0;
  localparam logic [2:0] SEL_ALARM = 3'h2;
  localparam logic [2:0] SEL_SYSTEM = 3'h4;
  // Frame lengths after the command byte.
  localparam logic [4:0] WRITE_FRAME = 5'h04;
  localparam logic [4:0] VREAD_BYTES = 5'h1A;
  localparam logic [4:0] IREAD_BYTES = 5'h03;
  localparam logic [4:0] CNT_MAX = 5'h1F;
  // Measurement widths.
  localparam int CELLS = 10;
  localparam int CONV_CH = 13;
  localparam int CONV_BITS = 14;
  localparam int CUR_BITS = 16;
  // Field positions and reset values.
  localparam int SYS_LOAD_EN = 5;
  localparam int ALARM_OPEN_BIT = 11;
  localparam logic ALARM_OPEN_RST = 1'b1;
  localparam logic [15:0] SYS_CTRL_RST = 16'h0000;
  localparam logic [9:0] BAL_RST = 10'h000;
  localparam logic [9:0] BAL_ALL = 10'h3FF;
  // Watchdog timing.
  localparam int CLK_MHZ = 200;
  localparam int WD_STEP_MS = 512;
  localparam int WD_MAX_MS = 120000;
  localparam int WD_STEP_CYCLES = WD_STEP_MS * 1000 * CLK_MHZ;
  localparam logic [7:0] WD_MAX_STEPS = 8'(WD_MAX_MS / WD_STEP_MS);
  localparam logic [1:0] CAP_CYCLES = 2'h3;
  // Cells allowed to discharge while cell n+1 is sampled.
  localparam logic [9:0] SAMPLE_MASK [CELLS] = '{
    10'h1C0, 10'h3B8, 10'h371, 10'h2E3, 10'h1C7,
    10'h38E, 10'h301, 10'h23F, 10'h07F, 10'h0FE};
  typedef enum logic [1:0] {
    ST_IDLE, ST_CMD, ST_DATA, ST_REPLY
  } frame_st_t;
endpackage : spi_cmd_pkg

// ### rtl/link_sync2.sv
`timescale 1ns/1ps
`default_nettype none
module link_sync2 #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Data.
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule : link_sync2
`default_nettype wire

// ### rtl/sample_guard.sv
`timescale 1ns/1ps
`default_nettype none
module sample_guard (
  // Cell under measurement, zero for none.
  input wire logic [3:0] sample_cell,
  // Balancing switches allowed on.
  output logic [9:0] allow
);
  always_comb begin
    allow = spi_cmd_pkg::BAL_ALL;
    if (sample_cell >= 4'h1 && sample_cell <= 4'hA) begin
      allow = spi_cmd_pkg::SAMPLE_MASK[sample_cell - 4'h1];
    end
  end
endmodule : sample_guard
`default_nettype wire

// ### rtl/cascaded_spi_command_interface.sv
// Functional notes
// - Host port runs clock idle high, sampled on the second (rising) edge.
// - Every unit on the link is an eight-bit byte.
// - Host data input is captured on each rising serial clock edge.
// - Reply bits change on falling edges, valid at the rising edge.
// - Command with data acts only if data bytes plus check byte sum to FF; reads and commands with no data bytes skip the sum.
// - Command byte: address nibble, three-bit code, odd parity bit.
// - Address all ones is broadcast; otherwise own address must match.
// - Four straps give the address; all ones means broadcast.
// - Code 000: broadcast sleeps, single clears fault flags.
// - Code 001: broadcast wakes, single writes balance, alarm or system.
// - Broadcast 010 sets charge, 011 discharge, except bottom unit.
// - Single 010 reads thirteen 14-bit conversion results.
// - Balancing stops after no accepted command for the programmed watchdog period.
// - Any accepted command re-enables balancing after watchdog stop.
// - Sampled cell and neighbours follow the fixed ten-row switch pattern.
// - Load detect enable drives load-detect output; comparator is reported.
// - Load pull resistor stays on while the discharge fault lasts.
// - Charger present when sense below threshold; status bit shows removal.
// - Regulator warns at first temperature, shuts down at second.
// - Traffic is forwarded upward; upper replies are relayed down.
// - Address updates until lock bit set; lock enables conversion.
// - Single 011 reads the 16-bit current result.
`timescale 1ns/1ps
`default_nettype none
module cascaded_spi_command_interface #(
  parameter int WD_TICK_CYCLES = spi_cmd_pkg::WD_STEP_CYCLES
) (
  // System clock and reset.
  input wire logic sys_clk,
  input wire logic nrst,
  // Host-side serial port.
  input wire logic host_clock_in,
  input wire logic host_select_in,
  input wire logic host_data_in,
  output logic host_data_out,
  // Upper-side serial port.
  output logic upper_clock_out,
  output logic upper_select_out,
  output logic upper_data_out,
  input wire logic upper_data_in,
  // Address straps.
  input wire logic addr_strap_3,
  input wire logic addr_strap_2,
  input wire logic addr_strap_1,
  input wire logic addr_strap_0,
  // Comparator levels from pins.
  input wire logic load_sense_pin,
  input wire logic charger_sense_pin,
  input wire logic ldo_temp_warn_in,
  input wire logic ldo_temp_crit_in,
  // Measurement and protection side.
  input wire logic [12:0][13:0] conv_result,
  input wire logic [15:0] current_result,
  input wire logic [3:0] sample_cell,
  input wire logic dsg_fault,
  // Configuration.
  input wire logic [7:0] comm_watchdog_period,
  input wire logic addr_lock,
  // Control and status.
  output logic [9:0] balance_drive,
  output logic load_detect_output,
  output logic load_pull_resistor,
  output logic fault_clear,
  output logic sleep_mode,
  output logic charge_state,
  output logic charger_present,
  output logic status_load_removed,
  output logic status_charger_removed,
  output logic status_balance_off,
  output logic ldo_warn,
  output logic ldo_shutdown,
  output logic conversion_enable,
  output logic alarm_open_check,
  output logic [15:0] system_ctrl,
  output logic [3:0] dev_address
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  function automatic logic odd_ok(input logic [7:0] b);
    return ^b;
  endfunction : odd_ok

  function automatic logic is_bcast(input logic [7:0] b);
    return b[7:4] == spi_cmd_pkg::ADDR_BCAST;
  endfunction : is_bcast

  // Link side on the serial clock.
  logic [2:0] bit_cnt_r;
  logic [7:0] rx_shift_r;
  logic [7:0] rx_byte_r;
  logic rx_tgl_r;
  logic [7:0] tx_shift_r;
  logic [7:0] tx_byte_r;
  logic reply_own_r;

  // Select high holds the link logic in reset between frames.
  always_ff @(posedge host_clock_in or negedge nrst
              or posedge host_select_in) begin
    if (!nrst) begin
      bit_cnt_r <= 3'h0;
      rx_shift_r <= 8'h00;
    end else if (host_select_in) begin
      bit_cnt_r <= 3'h0;
      rx_shift_r <= 8'h00;
    end else begin
      bit_cnt_r <= bit_cnt_r + 3'h1;
      rx_shift_r <= {rx_shift_r[6:0], host_data_in};
    end
  end

  always_ff @(posedge host_clock_in or negedge nrst) begin
    if (!nrst) begin
      rx_byte_r <= 8'h00;
      rx_tgl_r <= 1'b0;
    end else if (!host_select_in && bit_cnt_r == spi_cmd_pkg::LAST_BIT) begin
      rx_byte_r <= {rx_shift_r[6:0], host_data_in};
      rx_tgl_r <= ~rx_tgl_r;
    end
  end

  // First falling edge of a byte loads it, later ones shift.
  always_ff @(negedge host_clock_in or negedge nrst
              or posedge host_select_in) begin
    if (!nrst) begin
      tx_shift_r <= spi_cmd_pkg::TX_IDLE;
    end else if (host_select_in) begin
      tx_shift_r <= spi_cmd_pkg::TX_IDLE;
    end else if (bit_cnt_r == 3'h0) begin
      tx_shift_r <= tx_byte_r;
    end else begin
      tx_shift_r <= {tx_shift_r[6:0], 1'b1};
    end
  end

  assign upper_clock_out = host_clock_in;
  assign upper_select_out = host_select_in;
  assign upper_data_out = host_data_in;
  assign host_data_out = reply_own_r ? tx_shift_r[7] : upper_data_in;

  // Crossing into the system clock.
  logic [9:0] sync_q;
  logic sel_s;
  logic tgl_s;
  logic [3:0] strap_s;
  logic load_s;
  logic chg_s;
  logic warn_s;
  logic crit_s;

  link_sync2 #(.WIDTH(10)) u_sync (
    .clk(sys_clk),
    .nrst(nrst),
    .d({host_select_in, rx_tgl_r, addr_strap_3, addr_strap_2,
        addr_strap_1, addr_strap_0, load_sense_pin, charger_sense_pin,
        ldo_temp_warn_in, ldo_temp_crit_in}),
    .q(sync_q)
  );
  assign {sel_s, tgl_s, strap_s, load_s, chg_s, warn_s, crit_s} = sync_q;

  logic sel_d_r;
  logic tgl_d_r;
  logic frame_start;
  logic frame_end;
  logic byte_evt;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sel_d_r <= 1'b0;
      tgl_d_r <= 1'b0;
    end else begin
      sel_d_r <= sel_s;
      tgl_d_r <= tgl_s;
    end
  end
  assign frame_start = ~sel_s & sel_d_r;
  assign frame_end = sel_s & ~sel_d_r;
  assign byte_evt = tgl_s ^ tgl_d_r;

  // Frame sequencing.
  spi_cmd_pkg::frame_st_t st_r;
  logic cmd_evt;
  logic rd_hit;
  logic [3:0] addr_r;

  assign cmd_evt = byte_evt && st_r == spi_cmd_pkg::ST_CMD;
  assign rd_hit = odd_ok(rx_byte_r) && rx_byte_r[7:4] == addr_r
    && !is_bcast(rx_byte_r)
    && (rx_byte_r[3:1] == spi_cmd_pkg::CODE_CHG_VREAD
     || rx_byte_r[3:1] == spi_cmd_pkg::CODE_DSG_IREAD);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= spi_cmd_pkg::ST_IDLE;
    end else begin
      case (st_r)
        spi_cmd_pkg::ST_IDLE: begin
          if (frame_start) st_r <= spi_cmd_pkg::ST_CMD;
        end
        spi_cmd_pkg::ST_CMD: begin
          if (frame_end) st_r <= spi_cmd_pkg::ST_IDLE;
          else if (byte_evt && rd_hit) st_r <= spi_cmd_pkg::ST_REPLY;
          else if (byte_evt) st_r <= spi_cmd_pkg::ST_DATA;
        end
        spi_cmd_pkg::ST_DATA, spi_cmd_pkg::ST_REPLY: begin
          if (frame_end) st_r <= spi_cmd_pkg::ST_IDLE;
        end
        default: st_r <= spi_cmd_pkg::ST_IDLE;
      endcase
    end
  end

  // Command and data bytes.
  logic [7:0] cmd_r;
  logic [4:0] byte_cnt_r;
  logic [7:0] sum_r;
  logic [31:0] win_r;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cmd_r <= 8'h00;
      byte_cnt_r <= 5'h00;
      sum_r <= 8'h00;
      win_r <= 32'h0000_0000;
    end else if (frame_start) begin
      byte_cnt_r <= 5'h00;
      sum_r <= 8'h00;
    end else if (cmd_evt) begin
      cmd_r <= rx_byte_r;
    end else if (byte_evt && st_r == spi_cmd_pkg::ST_DATA) begin
      if (byte_cnt_r != spi_cmd_pkg::CNT_MAX) begin
        byte_cnt_r <= byte_cnt_r + 5'h01;
      end
      sum_r <= sum_r + rx_byte_r;
      win_r <= {win_r[23:0], rx_byte_r};
    end
  end

  logic cmd_ok;
  logic bcast;
  logic [2:0] code;
  logic wr_ok;

  assign bcast = is_bcast(cmd_r);
  assign code = cmd_r[3:1];
  assign cmd_ok = frame_end && odd_ok(cmd_r)
    && (bcast || cmd_r[7:4] == addr_r)
    && (st_r == spi_cmd_pkg::ST_REPLY || (st_r == spi_cmd_pkg::ST_DATA
    && (byte_cnt_r == 5'h00 || sum_r == spi_cmd_pkg::SUM_OK)));
  assign wr_ok = cmd_ok && !bcast && code == spi_cmd_pkg::CODE_WAKE_SET
    && byte_cnt_r == spi_cmd_pkg::WRITE_FRAME;

  // Own address from the straps.
  logic [1:0] cap_cnt_r;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cap_cnt_r <= spi_cmd_pkg::CAP_CYCLES;
      addr_r <= 4'h0;
    end else begin
      if (cap_cnt_r != 2'h0) cap_cnt_r <= cap_cnt_r - 2'h1;
      if (!addr_lock && (cap_cnt_r != 2'h0 || (cmd_ok && bcast
          && code == spi_cmd_pkg::CODE_ADDR_UPD))) begin
        addr_r <= strap_s;
      end
    end
  end
  assign dev_address = addr_r;

  // Command effects.
  logic [9:0] bal_set_r;
  logic set_ok_r;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sleep_mode <= 1'b0;
      charge_state <= 1'b0;
      fault_clear <= 1'b0;
      bal_set_r <= spi_cmd_pkg::BAL_RST;
      alarm_open_check <= spi_cmd_pkg::ALARM_OPEN_RST;
      system_ctrl <= spi_cmd_pkg::SYS_CTRL_RST;
      set_ok_r <= 1'b0;
      conversion_enable <= 1'b0;
    end else begin
      conversion_enable <= addr_lock;
      fault_clear <= cmd_ok && !bcast
        && code == spi_cmd_pkg::CODE_SLEEP_CLR;
      if (cmd_ok && bcast) begin
        case (code)
          spi_cmd_pkg::CODE_SLEEP_CLR: sleep_mode <= 1'b1;
          spi_cmd_pkg::CODE_WAKE_SET: sleep_mode <= 1'b0;
          spi_cmd_pkg::CODE_CHG_VREAD: begin
            if (addr_r != spi_cmd_pkg::ADDR_BOTTOM) charge_state <= 1'b1;
          end
          spi_cmd_pkg::CODE_DSG_IREAD: begin
            if (addr_r != spi_cmd_pkg::ADDR_BOTTOM) charge_state <= 1'b0;
          end
          default: ;
        endcase
      end
      if (wr_ok) begin
        set_ok_r <= 1'b1;
        case (win_r[31:29])
          spi_cmd_pkg::SEL_BALANCE: bal_set_r <= win_r[17:8];
          spi_cmd_pkg::SEL_ALARM: begin
            alarm_open_check <= win_r[8 + spi_cmd_pkg::ALARM_OPEN_BIT];
          end
          spi_cmd_pkg::SEL_SYSTEM: system_ctrl <= win_r[23:8];
          default: ;
        endcase
      end
    end
  end

  // Read replies.
  logic [13:0] snap_r [spi_cmd_pkg::CONV_CH];
  logic [15:0] cur_snap_r;
  logic kind_volt_r;
  logic load_r;
  logic [4:0] rep_idx_r;
  logic [7:0] rep_sum_r;
  logic [7:0] rep_data;
  logic [3:0] rep_ch;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < spi_cmd_pkg::CONV_CH; i++) snap_r[i] <= 14'h0000;
      cur_snap_r <= 16'h0000;
    end else if (cmd_evt && rd_hit) begin
      for (int i = 0; i < spi_cmd_pkg::CONV_CH; i++) begin
        snap_r[i] <= conv_result[i];
      end
      cur_snap_r <= current_result;
    end
  end

  always_comb begin
    rep_data = spi_cmd_pkg::TX_IDLE;
    rep_ch = rep_idx_r[4:1];
    if (kind_volt_r) begin
      if (rep_idx_r < spi_cmd_pkg::VREAD_BYTES) begin
        rep_data = rep_idx_r[0] ? snap_r[rep_ch][7:0]
                                : {2'h0, snap_r[rep_ch][13:8]};
      end else if (rep_idx_r == spi_cmd_pkg::VREAD_BYTES) begin
        rep_data = spi_cmd_pkg::SUM_OK - rep_sum_r;
      end
    end else begin
      case (rep_idx_r)
        5'h00: rep_data = {3'h0, set_ok_r, 4'h0};
        5'h01: rep_data = cur_snap_r[15:8];
        5'h02: rep_data = cur_snap_r[7:0];
        spi_cmd_pkg::IREAD_BYTES: rep_data = spi_cmd_pkg::SUM_OK - rep_sum_r;
        default: rep_data = spi_cmd_pkg::TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      reply_own_r <= 1'b0;
      kind_volt_r <= 1'b0;
      load_r <= 1'b0;
      rep_idx_r <= 5'h00;
      rep_sum_r <= 8'h00;
      tx_byte_r <= spi_cmd_pkg::TX_IDLE;
    end else begin
      load_r <= (cmd_evt && rd_hit)
        || (byte_evt && st_r == spi_cmd_pkg::ST_REPLY);
      if (frame_end) begin
        reply_own_r <= 1'b0;
        tx_byte_r <= spi_cmd_pkg::TX_IDLE;
      end else if (cmd_evt && rd_hit) begin
        reply_own_r <= 1'b1;
        kind_volt_r <= rx_byte_r[3:1] == spi_cmd_pkg::CODE_CHG_VREAD;
        rep_idx_r <= 5'h00;
        rep_sum_r <= 8'h00;
      end else if (load_r) begin
        tx_byte_r <= rep_data;
        rep_sum_r <= rep_sum_r + rep_data;
        if (rep_idx_r != spi_cmd_pkg::CNT_MAX) rep_idx_r <= rep_idx_r + 5'h01;
      end
    end
  end

  // Communication watchdog.
  logic [26:0] tick_cnt_r;
  logic [7:0] wd_steps_r;
  logic [7:0] wd_limit;
  logic wd_expire;

  assign wd_limit = comm_watchdog_period > spi_cmd_pkg::WD_MAX_STEPS
    ? spi_cmd_pkg::WD_MAX_STEPS : comm_watchdog_period;
  assign wd_expire = wd_limit != 8'h00 && wd_steps_r >= wd_limit;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tick_cnt_r <= 27'h0000000;
      wd_steps_r <= 8'h00;
    end else begin
      if (cmd_ok || tick_cnt_r == 27'(WD_TICK_CYCLES - 1)) begin
        tick_cnt_r <= 27'h0000000;
      end else begin
        tick_cnt_r <= tick_cnt_r + 27'h0000001;
      end
      if (cmd_ok) begin
        wd_steps_r <= 8'h00;
      end else if (tick_cnt_r == 27'(WD_TICK_CYCLES - 1)
                   && wd_steps_r != 8'hFF) begin
        wd_steps_r <= wd_steps_r + 8'h01;
      end
    end
  end

  // Balancing, load and charger status.
  logic [9:0] allow;

  sample_guard u_guard (
    .sample_cell(sample_cell),
    .allow(allow)
  );

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      status_balance_off <= 1'b0;
      balance_drive <= spi_cmd_pkg::BAL_RST;
      load_detect_output <= 1'b0;
      load_pull_resistor <= 1'b0;
      status_load_removed <= 1'b0;
      status_charger_removed <= 1'b0;
      charger_present <= 1'b0;
      ldo_warn <= 1'b0;
      ldo_shutdown <= 1'b0;
    end else begin
      // An accepted command restarts the silence count in the same cycle,
      // so it must win here or the stop flag could never be released.
      if (cmd_ok) status_balance_off <= 1'b0;
      else if (wd_expire) status_balance_off <= 1'b1;
      balance_drive <= bal_set_r & allow
        & {10{~status_balance_off}};
      load_detect_output <= system_ctrl[spi_cmd_pkg::SYS_LOAD_EN];
      if (!dsg_fault) load_pull_resistor <= 1'b0;
      else if (system_ctrl[spi_cmd_pkg::SYS_LOAD_EN]) load_pull_resistor <= 1'b1;
      status_load_removed <= load_s;
      status_charger_removed <= chg_s;
      charger_present <= ~chg_s;
      ldo_warn <= warn_s;
      ldo_shutdown <= crit_s;
    end
  end

  sequence s_bcast_cmd(logic [2:0] c);
    cmd_ok && bcast && code == c;
  endsequence

  a_parity_gate: assert property (cmd_ok |-> ^cmd_r)
    else $error("command accepted with even parity");
  a_sum_gate: assert property (cmd_ok && st_r == spi_cmd_pkg::ST_DATA
    && byte_cnt_r != 5'h00 |-> sum_r == 8'hFF)
    else $error("command accepted with bad byte sum");
  a_addr_gate: assert property (cmd_ok |-> cmd_r[7:4] == 4'hF
    || cmd_r[7:4] == addr_r)
    else $error("command accepted for another address");
  a_sleep_entry: assert property (s_bcast_cmd(3'h0) |=> sleep_mode)
    else $error("broadcast sleep not taken");
  a_wake_entry: assert property (s_bcast_cmd(3'h1) |=> !sleep_mode)
    else $error("broadcast wake not taken");
  a_charge_set: assert property (s_bcast_cmd(3'h2) ##0 addr_r != 4'h0
    |=> charge_state)
    else $error("charge state not set");
  a_read_reply: assert property (cmd_evt && rd_hit && !frame_end
    |=> reply_own_r ##1 tx_byte_r == $past(rep_data))
    else $error("read reply not started");
  a_wd_stop: assert property (wd_expire && !cmd_ok |=> status_balance_off
    ##1 balance_drive == 10'h000)
    else $error("watchdog did not stop balancing");
  a_wd_release: assert property (cmd_ok
    |=> !status_balance_off)
    else $error("accepted command did not release balancing");
  a_sample_mask: assert property ((balance_drive & ~$past(allow)) == 10'h000)
    else $error("sampled cell neighbour switch on");
  a_load_detect: assert property ($rose(system_ctrl[5])
    |=> load_detect_output)
    else $error("load detect output not raised");
  a_pull_hold: assert property (load_pull_resistor && dsg_fault
    |=> load_pull_resistor)
    else $error("pull resistor dropped during fault");
  a_rx_capture: assert property (@(posedge host_clock_in) disable iff (!nrst)
    !host_select_in && bit_cnt_r == 3'h7
    |=> rx_byte_r[0] == $past(host_data_in))
    else $error("last bit of byte not captured");
endmodule : cascaded_spi_command_interface
`default_nettype wire

// ### bench/host_link_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_link_model (
  // Serial port toward the device.
  output logic host_clock_in,
  output logic host_select_in,
  output logic host_data_in,
  input wire logic host_data_out
);
  logic [7:0] tx_q[$];
  logic [7:0] rx_q[$];
  initial begin
    host_clock_in = 1'b1;
    host_select_in = 1'b1;
    host_data_in = 1'b1;
  end
  task automatic run_frame(input int half_ns);
    logic [7:0] rx;
    rx_q = {};
    host_select_in = 1'b0;
    #(half_ns);
    foreach (tx_q[i]) begin
      for (int b = 7; b >= 0; b--) begin
        host_clock_in = 1'b0;
        host_data_in = tx_q[i][b];
        #(half_ns);
        host_clock_in = 1'b1;
        rx[b] = host_data_out;
        #(half_ns);
      end
      rx_q.push_back(rx);
      if (i == 0) #(2 * half_ns);
    end
    host_data_in = 1'b1;
    host_select_in = 1'b1;
    #(half_ns);
  endtask : run_frame
endmodule : host_link_model
`default_nettype wire

// ### bench/cascaded_spi_command_interface_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module cascaded_spi_command_interface_tb_top;
  logic sys_clk, nrst, upper_data_in, load_sense_pin, charger_sense_pin;
  logic ldo_temp_warn_in, ldo_temp_crit_in, dsg_fault, addr_lock;
  logic host_clock_in, host_select_in, host_data_in, host_data_out;
  logic upper_clock_out, upper_select_out, upper_data_out;
  logic load_detect_output, load_pull_resistor, fault_clear, sleep_mode;
  logic charge_state, charger_present, status_load_removed, ldo_warn;
  logic status_charger_removed, status_balance_off, ldo_shutdown;
  logic conversion_enable, alarm_open_check;
  logic [3:0] strap, sample_cell, dev_address, other;
  logic [12:0][13:0] conv_result;
  logic [15:0] current_result, system_ctrl;
  logic [7:0] comm_watchdog_period;
  logic [9:0] balance_drive, bal;
  logic [31:0] e;
  bit slp_m, chg_m;
  int miscompares, tests_run, clr_n;
  cascaded_spi_command_interface #(.WD_TICK_CYCLES(20)) DUT (
    .sys_clk, .nrst, .host_clock_in, .host_select_in, .host_data_in,
    .host_data_out, .upper_clock_out, .upper_select_out, .upper_data_out,
    .upper_data_in, .addr_strap_3(strap[3]), .addr_strap_2(strap[2]),
    .addr_strap_1(strap[1]), .addr_strap_0(strap[0]), .load_sense_pin,
    .charger_sense_pin, .ldo_temp_warn_in, .ldo_temp_crit_in, .conv_result,
    .current_result, .sample_cell, .dsg_fault, .comm_watchdog_period,
    .addr_lock, .balance_drive, .load_detect_output, .load_pull_resistor,
    .fault_clear, .sleep_mode, .charge_state, .charger_present,
    .status_load_removed, .status_charger_removed, .status_balance_off,
    .ldo_warn, .ldo_shutdown, .conversion_enable, .alarm_open_check,
    .system_ctrl, .dev_address);
  host_link_model HOST (.host_clock_in, .host_select_in, .host_data_in,
    .host_data_out);
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) if (fault_clear === 1'b1) clr_n++;
  task automatic check(input string what, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  function automatic logic [7:0] cmd(input logic [3:0] a, logic [2:0] c);
    return {a, c, ~^{a, c}};
  endfunction : cmd
  task automatic wr(input logic [3:0] a, logic [2:0] c, logic [23:0] d,
    bit dat, bit bad, int half = 40);
    logic [7:0] s;
    s = 8'hFF - (d[23:16] + d[15:8] + d[7:0]) + {7'h0, bad};
    HOST.tx_q = {cmd(a, c)};
    if (dat) HOST.tx_q = {cmd(a, c), d[23:16], d[15:8], d[7:0], s};
    HOST.run_frame(half);
    tick(8);
  endtask : wr
  initial begin
    #400us;
    miscompares++;
    summarize();
  end
  initial begin
    nrst = 1'b0;
    e = $urandom(40755);
    {upper_data_in, load_sense_pin, charger_sense_pin, dsg_fault} = 4'h8;
    {ldo_temp_warn_in, ldo_temp_crit_in, addr_lock} = 3'h0;
    strap = 4'($urandom_range(14, 0));
    other = (strap == 4'hE) ? 4'h0 : strap + 4'h1;
    sample_cell = 4'h0;
    conv_result = {13{14'($urandom)}};
    current_result = 16'h0000;
    comm_watchdog_period = 8'h00;
    tick(8);
    nrst = 1'b1;
    tick(6);
    check("address", dev_address, strap);
    check("alarm open", alarm_open_check, 1'b1);
    repeat (8) begin
      {load_sense_pin, charger_sense_pin, ldo_temp_warn_in, ldo_temp_crit_in,
        upper_data_in, addr_lock} = 6'($urandom);
      tick(5);
      check("load", status_load_removed, load_sense_pin);
      check("charger", {charger_present, status_charger_removed},
        {~charger_sense_pin, charger_sense_pin});
      check("ldo", {ldo_warn, ldo_shutdown},
        {ldo_temp_warn_in, ldo_temp_crit_in});
      check("relay", host_data_out, upper_data_in);
      check("forward", {upper_clock_out, upper_select_out, upper_data_out},
        3'h7);
      check("lock", conversion_enable, addr_lock);
    end
    $display("test pins done");
    bal = 10'($urandom);
    wr(strap, 3'h1, {14'h0, bal}, 1, 0);
    check("balance", balance_drive, bal);
    wr(strap, 3'h1, {14'h0, ~bal}, 1, 1);
    check("bad sum", balance_drive, bal);
    wr(other, 3'h1, {14'h0, ~bal}, 1, 0);
    check("other address", balance_drive, bal);
    wr(strap, 3'h1, 24'h3FF, 1, 0, 400);
    check("slow frame", balance_drive, 10'h3FF);
    for (int k = 1; k <= 10; k++) begin
      sample_cell = 4'(k);
      tick(3);
      check("sample", balance_drive, spi_cmd_pkg::SAMPLE_MASK[k-1]);
    end
    sample_cell = 4'h0;
    $display("test balance done");
    wr(strap, 3'h1, 24'h800020, 1, 0);
    check("system", {system_ctrl, load_detect_output}, 17'h00041);
    dsg_fault = 1'b1;
    tick(3);
    check("pull on", load_pull_resistor, 1'b1);
    dsg_fault = 1'b0;
    tick(3);
    check("pull off", load_pull_resistor, 1'b0);
    for (int c = 0; c < 4; c++) begin
      wr(4'hF, 3'(c), 24'h0, 0, 0);
      if (c < 2) slp_m = (c == 0);
      else chg_m = (c == 2) && (strap != 4'h0);
      check("sleep", sleep_mode, slp_m);
      check("charge state", charge_state, chg_m);
    end
    wr(strap, 3'h0, 24'h0, 0, 0);
    check("fault clear", clr_n, 1);
    $display("test commands done");
    current_result = 16'($urandom);
    HOST.tx_q = {cmd(strap, 3'h3), 8'hFF, 8'hFF, 8'hFF, 8'hFF};
    HOST.run_frame(40);
    e = {8'h10, current_result, 8'h00};
    e[7:0] = 8'hFF - (e[31:24] + e[23:16] + e[15:8]);
    check("reply", {HOST.rx_q[1], HOST.rx_q[2], HOST.rx_q[3], HOST.rx_q[4]},
      e);
    $display("test read done");
    tick(8);
    comm_watchdog_period = 8'h02;
    tick(60);
    check("dog stop", {status_balance_off, balance_drive}, 11'h400);
    wr(4'hF, 3'h1, 24'h0, 0, 0);
    check("dog resume", {status_balance_off, balance_drive}, 11'h3FF);
    $display("test watchdog done");
    summarize();
  end
endmodule : cascaded_spi_command_interface_tb_top
`default_nettype wire
